// >>> rtl/loop_mode_params.svh
`ifndef LOOP_MODE_PARAMS_SVH
`define LOOP_MODE_PARAMS_SVH

// ----------------------------------------------------------------
// loop table word offsets (word index inside one loop's table)
// ----------------------------------------------------------------
`define OFF_MODE_ONE 6'h00
`define OFF_MODE_TWO 6'h01
`define OFF_LOCAL_SP 6'h02
`define OFF_INTEG 6'h04
`define OFF_OUTPUT 6'h05
`define OFF_STATUS 6'h06
`define OFF_SP_LO 6'h26
`define OFF_SP_HI 6'h27
`define OFF_REMOTE_PTR 6'h32

// global control word, word index (byte address is four times this)
`define CTRL_INDEX 10'h100

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BIT_TRANSFER_TYPE 3
`define BIT_VELOCITY 5
`define BIT_INDEPENDENT 15
`define BIT_SP_LIMIT_EN 3
`define BIT_CTRL_RUN 8

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define MODE_ONE_RST 16'h0000
`define REMOTE_PTR_RST 16'h0000
`define LOOP_EN_RST 4'h0
`define SETPOINT_RST 16'h0000

`endif

// >>> rtl/loop_mode_pkg.sv
package loop_mode_pkg;

  // loop modes, coded as the status word shows them
  typedef enum logic [2:0] {
    MODE_MANUAL = 3'h1,
    MODE_AUTO = 3'h2,
    MODE_CASCADE = 3'h4
  } loop_mode_t;

  // evaluation sequencer states
  typedef enum logic [11:0] {
    ST_IDLE = 12'h001,
    ST_EVAL = 12'h002,
    ST_FIX = 12'h004,
    ST_RD_OUT = 12'h008,
    ST_BIAS = 12'h010,
    ST_SP_PV = 12'h020,
    ST_OUTER = 12'h040,
    ST_RD_FMT = 12'h080,
    ST_RD_LO = 12'h100,
    ST_RD_HI = 12'h200,
    ST_RD_SP = 12'h400,
    ST_CLAMP = 12'h800
  } seq_state_t;

  // one 16-bit word per loop
  typedef logic [3:0][15:0] word_vec_t;

  // per-loop result seen by the calculation engine
  typedef struct packed {
    logic calc_run;
    loop_mode_t mode;
    logic [15:0] setpoint;
  } loop_status_t;

  typedef loop_status_t [3:0] loop_status_vec_t;

endpackage

// >>> rtl/loop_table_mem.sv
// ----------------------------------------------------------------
// single-port table memory, registered read data
// ----------------------------------------------------------------
module loop_table_mem #(
  parameter int AW = 8,
  parameter int DW = 16
) (
  // clock
  input wire logic clk,
  // access port
  input wire logic we,
  input wire logic re,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic [DW-1:0] rdata_r;

  // no reset on the array: software must load a table before use
  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    if (re) begin
      rdata_r <= mem[addr];
    end
  end

  assign rdata = rdata_r;

endmodule

// >>> rtl/pid_loop_mode_manager.sv
// Functional notes
// - loops following controller go Manual in Program state; no calculations run.
// - independent loops change mode in Program too; each loop's mode is recorded as desired only in Run, except the Manual loaded when the loop is enabled.
// - after power restore in Run, loops regain their recorded modes.
// - on Program-to-Run, following loops return to their recorded modes.
// - loops are enabled only in Program state and start in Manual.
// - mode comes from request bits 0..2 of the first mode word.
// - mode requests of following loops are ignored in Program state.
// - outer loop cannot go Manual-to-Auto until inner loop is Cascade.
// - a loop with an error condition stops calculating at once and goes to Manual at the next evaluation.
// - inner loop leaving Cascade forces its outer loop to Manual.
// - bit 3 of first mode word picks transfer type I or II.
// - type I Manual-to-Auto loads bias in position form, setpoint takes process variable.
// - type I Auto-to-Cascade sets outer output to inner process variable.
// - type II only loads bias on Manual-to-Auto in position form.
// - bits 0..1 of second mode word give 12/15 bit, uni/bipolar format.
// - bit 3 of second mode word clamps setpoint between limit words.
// - clamp acts internally; stored setpoint word keeps any written value.
// - limit words are re-read before every loop calculation.
// - Auto and Manual take setpoint from the local setpoint word.
// - Cascade fetches setpoint through the remote pointer word.
// - request bits are cleared once read.
// - actual mode is shown in bits 0..2 of the status word.
// - bit 15 of first mode word selects following or independent.
// - direct change from Manual to Cascade is refused.
`include "loop_mode_params.svh"

module pid_loop_mode_manager (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // apb register slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // controller state and loop inputs
  input wire logic run_state,
  input wire logic calc_tick,
  input wire logic power_fail_pin,
  input wire logic [3:0] loop_error,
  input wire loop_mode_pkg::word_vec_t process_variable,
  // per-loop results
  output loop_mode_pkg::loop_status_vec_t loop_status
);

  logic pf_meta_r, pf_sync_r, pf_prev_r, run_prev_r;
  logic restore_run_r, restore_pwr_r, tick_pend_r;
  loop_mode_pkg::word_vec_t mode_one_r, remote_ptr_r;
  logic [3:0] loop_en_r, m2a_r, a2c_r;
  loop_mode_pkg::loop_mode_t [3:0] mode_r, desired_r;
  loop_mode_pkg::seq_state_t state_r, state_nxt;
  logic [1:0] loop_r, fmt_r;
  logic lim_en_r;
  logic [15:0] lo_r, hi_r;
  loop_mode_pkg::loop_status_vec_t status_r;
  logic pready_r, pslverr_r, rd_pend_r;
  logic [31:0] prdata_r;
  logic [15:0] mem_rdata;
  logic [3:0] pair_ok, inner_block, halted;
  logic [3:0][2:0] eval_mode;
  logic [3:0][3:0] inner_hit;
  logic a_ctrl, apb_wr;

  // ----------------------------------------------------------------
  // format conversion
  // ----------------------------------------------------------------
  // bipolar formats sign-extend from the top bit of 12 or 15
  function automatic logic signed [16:0] to_num(input logic [15:0] v,
                                                input logic [1:0] fmt);
    logic signed [16:0] n;
    n = $signed({1'b0, v});
    if (fmt == 2'h1) begin
      n = $signed({{5{v[11]}}, v[11:0]});
    end else if (fmt == 2'h3) begin
      n = $signed({{2{v[14]}}, v[14:0]});
    end
    return n;
  endfunction

  // ----------------------------------------------------------------
  // controller state inputs
  // ----------------------------------------------------------------
  // power monitor pin is asynchronous, so it is synchronised first
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pf_meta_r <= 1'b0;
      pf_sync_r <= 1'b0;
      pf_prev_r <= 1'b0;
      run_prev_r <= 1'b0;
    end else begin
      pf_meta_r <= power_fail_pin;
      pf_sync_r <= pf_meta_r;
      pf_prev_r <= pf_sync_r;
      run_prev_r <= run_state;
    end
  end

  wire logic run_rise = run_state & ~run_prev_r;
  wire logic pf_fall = pf_prev_r & ~pf_sync_r;
  wire logic is_idle = state_r == loop_mode_pkg::ST_IDLE;
  wire logic start = is_idle & (calc_tick | tick_pend_r) & ~(psel & penable);
  wire logic in_eval = state_r == loop_mode_pkg::ST_EVAL;
  wire logic in_fix = state_r == loop_mode_pkg::ST_FIX;
  wire logic rec_ok = run_state & ~pf_sync_r;

  // restore requests wait for the next evaluation; a new event wins
  // over the clear so that a restore is never lost
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      restore_run_r <= 1'b0;
      restore_pwr_r <= 1'b0;
      tick_pend_r <= 1'b0;
    end else begin
      restore_run_r <= run_rise | (restore_run_r & ~in_eval);
      restore_pwr_r <= (pf_fall & run_state) | (restore_pwr_r & ~in_eval);
      tick_pend_r <= (calc_tick & ~start) | (tick_pend_r & ~start);
    end
  end

  // ----------------------------------------------------------------
  // per-loop mode arbitration
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 4; i++) begin : g_loop
    wire logic [2:0] req = mode_one_r[i][2:0];
    wire logic one_hot = (req == 3'h1) | (req == 3'h2) | (req == 3'h4);
    wire logic follows = ~mode_one_r[i][`BIT_INDEPENDENT];
    wire logic restore = restore_pwr_r | (restore_run_r & follows);
    wire logic [2:0] base = restore ? desired_r[i] : mode_r[i];
    wire logic from_man = base == loop_mode_pkg::MODE_MANUAL;
    wire logic ok_man = req == loop_mode_pkg::MODE_MANUAL;
    wire logic ok_auto = (req == loop_mode_pkg::MODE_AUTO) &
                         (~from_man | ~inner_block[i]);
    wire logic ok_cas = (req == loop_mode_pkg::MODE_CASCADE) &
                        ~from_man & pair_ok[i];
    // following loops are held in Manual outside Run
    assign halted[i] = (follows & ~run_state) | pf_sync_r | ~loop_en_r[i];
    // a remote pointer naming another loop's output makes a pair
    assign pair_ok[i] = loop_en_r[i] & (remote_ptr_r[i][5:0] == `OFF_OUTPUT) &
                        (remote_ptr_r[i][7:6] != 2'(i));
    for (genvar j = 0; j < 4; j++) begin : g_inner
      assign inner_hit[i][j] = pair_ok[j] & (remote_ptr_r[j][7:6] == 2'(i)) &
                               (mode_r[j] != loop_mode_pkg::MODE_CASCADE);
    end
    assign inner_block[i] = |inner_hit[i];
    // halt and error override any request; a refused request keeps base
    assign eval_mode[i] = (halted[i] | loop_error[i]) ? 3'(loop_mode_pkg::MODE_MANUAL) :
                          (one_hot & (ok_man | ok_auto | ok_cas)) ? req : base;
  end

  // mode, recorded mode and transfer flags
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < 4; i++) begin
        mode_r[i] <= loop_mode_pkg::MODE_MANUAL;
        desired_r[i] <= loop_mode_pkg::MODE_MANUAL;
      end
      m2a_r <= 4'h0;
      a2c_r <= 4'h0;
    end else if (in_eval) begin
      for (int i = 0; i < 4; i++) begin
        mode_r[i] <= loop_mode_pkg::loop_mode_t'(eval_mode[i]);
        if (rec_ok) begin
          desired_r[i] <= loop_mode_pkg::loop_mode_t'(eval_mode[i]);
        end
        m2a_r[i] <= (mode_r[i] == loop_mode_pkg::MODE_MANUAL) &
                    (eval_mode[i] == loop_mode_pkg::MODE_AUTO);
        a2c_r[i] <= (mode_r[i] == loop_mode_pkg::MODE_AUTO) &
                    (eval_mode[i] == loop_mode_pkg::MODE_CASCADE);
      end
    end else if (in_fix) begin
      // second pass sees the inner loops' new modes without a comb loop
      for (int i = 0; i < 4; i++) begin
        if (inner_block[i]) begin
          mode_r[i] <= loop_mode_pkg::MODE_MANUAL;
          m2a_r[i] <= 1'b0;
          if (rec_ok) begin
            desired_r[i] <= loop_mode_pkg::MODE_MANUAL;
          end
        end
      end
    end else if (apb_wr & a_ctrl & ~run_state) begin
      for (int i = 0; i < 4; i++) begin
        if (pwdata[i] & ~loop_en_r[i]) begin
          mode_r[i] <= loop_mode_pkg::MODE_MANUAL;
          desired_r[i] <= loop_mode_pkg::MODE_MANUAL;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // evaluation sequencer
  // ----------------------------------------------------------------
  wire logic last_loop = loop_r == 2'h3;

  // one pass per calculation: modes, then per loop transfer and setpoint
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      loop_mode_pkg::ST_IDLE: begin
        if (start) begin
          state_nxt = loop_mode_pkg::ST_EVAL;
        end
      end
      loop_mode_pkg::ST_EVAL: state_nxt = loop_mode_pkg::ST_FIX;
      loop_mode_pkg::ST_FIX: state_nxt = loop_mode_pkg::ST_RD_OUT;
      loop_mode_pkg::ST_RD_OUT: state_nxt = loop_mode_pkg::ST_BIAS;
      loop_mode_pkg::ST_BIAS: state_nxt = loop_mode_pkg::ST_SP_PV;
      loop_mode_pkg::ST_SP_PV: state_nxt = loop_mode_pkg::ST_OUTER;
      loop_mode_pkg::ST_OUTER: state_nxt = loop_mode_pkg::ST_RD_FMT;
      loop_mode_pkg::ST_RD_FMT: state_nxt = loop_mode_pkg::ST_RD_LO;
      loop_mode_pkg::ST_RD_LO: state_nxt = loop_mode_pkg::ST_RD_HI;
      loop_mode_pkg::ST_RD_HI: state_nxt = loop_mode_pkg::ST_RD_SP;
      loop_mode_pkg::ST_RD_SP: state_nxt = loop_mode_pkg::ST_CLAMP;
      loop_mode_pkg::ST_CLAMP: begin
        state_nxt = last_loop ? loop_mode_pkg::ST_IDLE : loop_mode_pkg::ST_RD_OUT;
      end
      default: state_nxt = loop_mode_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_r <= loop_mode_pkg::ST_IDLE;
      loop_r <= 2'h0;
    end else begin
      state_r <= state_nxt;
      if (in_eval) begin
        loop_r <= 2'h0;
      end else if (state_r == loop_mode_pkg::ST_CLAMP) begin
        loop_r <= loop_r + 2'h1;
      end
    end
  end

  // limit words are fetched afresh each pass
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      fmt_r <= 2'h0;
      lim_en_r <= 1'b0;
      lo_r <= 16'h0000;
      hi_r <= 16'h0000;
    end else if (state_r == loop_mode_pkg::ST_RD_LO) begin
      fmt_r <= mem_rdata[1:0];
      lim_en_r <= mem_rdata[`BIT_SP_LIMIT_EN];
    end else if (state_r == loop_mode_pkg::ST_RD_HI) begin
      lo_r <= mem_rdata;
    end else if (state_r == loop_mode_pkg::ST_RD_SP) begin
      hi_r <= mem_rdata;
    end
  end

  // ----------------------------------------------------------------
  // transfer actions and setpoint fetch
  // ----------------------------------------------------------------
  wire logic [15:0] cur_one = mode_one_r[loop_r];
  wire logic [15:0] cur_ptr = remote_ptr_r[loop_r];
  wire logic cur_type2 = cur_one[`BIT_TRANSFER_TYPE];
  wire logic cur_vel = cur_one[`BIT_VELOCITY];
  wire logic [15:0] cur_pv = process_variable[loop_r];
  wire logic cur_cas = mode_r[loop_r] == loop_mode_pkg::MODE_CASCADE;
  wire logic cur_m2a = m2a_r[loop_r];

  // bias load is position form only; setpoint copy is type I only
  wire logic do_bias = (state_r == loop_mode_pkg::ST_BIAS) & cur_m2a & ~cur_vel;
  wire logic do_sp_pv = (state_r == loop_mode_pkg::ST_SP_PV) & cur_m2a & ~cur_type2;
  wire logic do_outer = (state_r == loop_mode_pkg::ST_OUTER) & a2c_r[loop_r] &
                        ~cur_type2 & pair_ok[loop_r];
  wire logic fsm_we = do_bias | do_sp_pv | do_outer;
  wire logic fsm_re = (state_r == loop_mode_pkg::ST_RD_OUT) |
                      (state_r == loop_mode_pkg::ST_RD_FMT) |
                      (state_r == loop_mode_pkg::ST_RD_LO) |
                      (state_r == loop_mode_pkg::ST_RD_HI) |
                      (state_r == loop_mode_pkg::ST_RD_SP);
  // cascade reads the outer loop's output through the pointer
  wire logic [7:0] sp_addr = cur_cas ? cur_ptr[7:0] : {loop_r, `OFF_LOCAL_SP};
  wire logic [7:0] fsm_addr =
    (state_r == loop_mode_pkg::ST_BIAS) ? {loop_r, `OFF_INTEG} :
    (state_r == loop_mode_pkg::ST_SP_PV) ? {loop_r, `OFF_LOCAL_SP} :
    (state_r == loop_mode_pkg::ST_OUTER) ? {cur_ptr[7:6], `OFF_OUTPUT} :
    (state_r == loop_mode_pkg::ST_RD_FMT) ? {loop_r, `OFF_MODE_TWO} :
    (state_r == loop_mode_pkg::ST_RD_LO) ? {loop_r, `OFF_SP_LO} :
    (state_r == loop_mode_pkg::ST_RD_HI) ? {loop_r, `OFF_SP_HI} :
    (state_r == loop_mode_pkg::ST_RD_SP) ? sp_addr : {loop_r, `OFF_OUTPUT};
  wire logic [15:0] fsm_wdata = do_bias ? mem_rdata : cur_pv;

  // clamp in the loop's own number format; stored word is untouched
  wire logic signed [16:0] sp_n = to_num(mem_rdata, fmt_r);
  wire logic signed [16:0] lo_n = to_num(lo_r, fmt_r);
  wire logic signed [16:0] hi_n = to_num(hi_r, fmt_r);
  wire logic [15:0] sp_used = ~lim_en_r ? mem_rdata :
                              (sp_n < lo_n) ? lo_r :
                              (sp_n > hi_n) ? hi_r : mem_rdata;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire logic [5:0] a_off = paddr[7:2];
  wire logic [1:0] a_loop = paddr[9:8];
  wire logic a_tbl = paddr[11:10] == 2'h0;
  assign a_ctrl = paddr[11:2] == `CTRL_INDEX;
  wire logic a_one = a_tbl & (a_off == `OFF_MODE_ONE);
  wire logic a_stat = a_tbl & (a_off == `OFF_STATUS);
  wire logic a_ptr = a_tbl & (a_off == `OFF_REMOTE_PTR);
  wire logic a_mem = a_tbl & ((a_off == `OFF_MODE_TWO) | (a_off == `OFF_LOCAL_SP) |
                     (a_off == `OFF_INTEG) | (a_off == `OFF_OUTPUT) |
                     (a_off == `OFF_SP_LO) | (a_off == `OFF_SP_HI));
  wire logic a_map = a_ctrl | a_one | a_stat | a_ptr | a_mem;
  wire logic a_bad = ~a_map | (pwrite & a_stat);
  // the bus is served only while the sequencer rests, which also
  // keeps the single memory port free of contention
  wire logic apb_act = psel & penable & is_idle & ~pready_r;
  wire logic apb_issue = apb_act & ~pwrite & a_mem & ~rd_pend_r;
  wire logic apb_answer = apb_act & ~apb_issue;
  wire logic apb_done = psel & penable & pready_r;
  assign apb_wr = apb_done & pwrite & ~pslverr_r;
  wire logic [31:0] rd_val =
    a_ctrl ? {23'h000000, run_state, 4'h0, loop_en_r} :
    a_one ? {16'h0000, mode_one_r[a_loop]} :
    a_stat ? {29'h00000000, mode_r[a_loop]} :
    a_ptr ? {16'h0000, remote_ptr_r[a_loop]} :
    a_mem ? {16'h0000, mem_rdata} : 32'h00000000;

  // registered answer: writes land at the completing edge only
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
      rd_pend_r <= 1'b0;
    end else if (apb_done) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      rd_pend_r <= 1'b0;
    end else if (apb_answer) begin
      pready_r <= 1'b1;
      pslverr_r <= a_bad;
      prdata_r <= pwrite ? 32'h00000000 : rd_val;
    end else if (apb_issue) begin
      rd_pend_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // software-written words held in flops
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      mode_one_r <= {4{`MODE_ONE_RST}};
      remote_ptr_r <= {4{`REMOTE_PTR_RST}};
      loop_en_r <= `LOOP_EN_RST;
    end else if (in_eval) begin
      // bits are cleared whether the request was honoured or not
      for (int i = 0; i < 4; i++) begin
        mode_one_r[i][2:0] <= 3'h0;
      end
    end else if (apb_wr) begin
      if (a_one) begin
        mode_one_r[a_loop] <= pwdata[15:0];
      end else if (a_ptr) begin
        remote_ptr_r[a_loop] <= pwdata[15:0];
      end else if (a_ctrl & ~run_state) begin
        loop_en_r <= pwdata[3:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // table memory
  // ----------------------------------------------------------------
  wire logic mem_we = fsm_we | (apb_wr & a_mem);
  wire logic mem_re = fsm_re | apb_issue;
  wire logic [7:0] mem_addr = is_idle ? {a_loop, a_off} : fsm_addr;
  wire logic [15:0] mem_wdata = is_idle ? pwdata[15:0] : fsm_wdata;

  loop_table_mem #(
    .AW(8),
    .DW(16)
  ) u_table (
    .clk(sys_clk),
    .we(mem_we),
    .re(mem_re),
    .addr(mem_addr),
    .wdata(mem_wdata),
    .rdata(mem_rdata)
  );

  // ----------------------------------------------------------------
  // loop results
  // ----------------------------------------------------------------
  // calculation runs only for enabled, non-halted, non-manual loops
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < 4; i++) begin
        status_r[i].calc_run <= 1'b0;
        status_r[i].mode <= loop_mode_pkg::MODE_MANUAL;
        status_r[i].setpoint <= `SETPOINT_RST;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        status_r[i].calc_run <= ~halted[i] & ~loop_error[i] &
                                (mode_r[i] != loop_mode_pkg::MODE_MANUAL);
        status_r[i].mode <= mode_r[i];
        if ((state_r == loop_mode_pkg::ST_CLAMP) & (loop_r == 2'(i))) begin
          status_r[i].setpoint <= sp_used;
        end
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign loop_status = status_r;

endmodule

// >>> verif/loop_mode_asserts.sv
module loop_mode_asserts (
  // clock, reset and apb slave side
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // loop side
  input wire logic calc_tick,
  input wire logic [3:0] loop_error,
  input wire loop_mode_pkg::loop_status_vec_t loop_status
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] man;
  logic [3:0] hot;
  // per-loop mode flags
  for (genvar i = 0; i < 4; i++) begin : g_mode
    assign man[i] = loop_status[i].mode == loop_mode_pkg::MODE_MANUAL;
    assign hot[i] = $onehot(loop_status[i].mode);
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // a four-loop pass ends well inside 80 cycles
  sequence err_tick; calc_tick && loop_error[2]; endsequence
  sequence go_manual; ##[1:80] man[2]; endsequence
  rst_state_a: assert property (disable iff (1'b0) reset |-> &man && !pready)
    else $error("reset state wrong");
  mode_code_a: assert property (hot == 4'hF)
    else $error("mode code not one-hot");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held");
  ready_access_a: assert property (pready |-> psel && penable && $past(psel))
    else $error("ready outside access");
  setup_quiet_a: assert property (psel && !penable |-> !pready)
    else $error("ready in setup");
  refuse_zero_a: assert property (pslverr |-> pready && (pwrite || prdata == 32'h0))
    else $error("refused read data");
  upper_zero_a: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits");
  error_manual_a: assert property (err_tick |-> go_manual)
    else $error("faulty loop not manual");
endmodule
bind pid_loop_mode_manager loop_mode_asserts u_loop_mode_asserts (.*);

// >>> verif/loop_table_user.sv
module loop_table_user (
  // apb master side
  input wire logic sys_clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] rdat;
  logic rerr;
  initial {psel, penable, pwrite, paddr, pwdata} = 47'h0;
  // request held until pready is seen; released lines show the inverse, not stale data
  task automatic xfer(input logic w, input logic [11:0] a, input logic [15:0] d);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, 16'h0000, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (!pready);
    {rdat, rerr} = {prdata, pslverr};
    {psel, penable, paddr, pwdata} <= {2'b00, ~a, ~{16'h0000, d}};
    @(posedge sys_clk);
  endtask
endmodule

// >>> verif/pid_loop_mode_manager_bench.sv
`include "loop_mode_params.svh"
module pid_loop_mode_manager_bench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [5:0] off; logic [15:0] wd; logic er; logic [15:0] rd;} row_t;
  logic sys_clk, reset, psel, penable, pwrite, pready, pslverr, run_state, calc_tick;
  logic power_fail_pin;
  logic [3:0] loop_error;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  loop_mode_pkg::word_vec_t process_variable;
  loop_mode_pkg::loop_status_vec_t loop_status;
  int bad_count = 0, n_checks = 0;
  // loop 1 words: written, write refused, read back; pointer makes loop 0 its outer
  row_t rows [4] = '{'{`OFF_MODE_TWO, 16'h000B, 1'b0, 16'h000B},
    '{`OFF_REMOTE_PTR, 16'h0005, 1'b0, 16'h0005},
    '{`OFF_STATUS, 16'hFFFF, 1'b1, 16'h0001}, '{6'h3F, 16'h5A5A, 1'b1, 16'h0000}};
  pid_loop_mode_manager u_pid_loop_mode_manager (.*);
  loop_table_user host (.*);
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // watchdog: the run needs under 1000 cycles
  initial begin
    repeat (5000) @(posedge sys_clk);
    bad_count++;
    final_report();
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  function automatic logic [11:0] ad(input logic [1:0] lp, input logic [5:0] off);
    return {2'b00, lp, off, 2'b00};
  endfunction
  task automatic put(input logic [1:0] lp, input logic [5:0] off, input logic [15:0] d);
    host.xfer(1'b1, ad(lp, off), d);
  endtask
  task automatic get(input logic [1:0] lp, input logic [5:0] off, input logic [15:0] e);
    host.xfer(1'b0, ad(lp, off), 16'h0000);
    check(host.rdat, {16'h0000, e});
  endtask
  // one pass; loop 3 settles 39 cycles after the tick
  task automatic pass();
    calc_tick <= 1'b1;
    @(posedge sys_clk);
    calc_tick <= 1'b0;
    repeat (60) @(posedge sys_clk);
  endtask
  initial begin
    {reset, run_state, calc_tick, power_fail_pin, loop_error} = 8'h80;
    process_variable = {16'h0000, 16'h0456, 16'h0000, 16'h0000};
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    check(loop_status[2], {1'b0, loop_mode_pkg::MODE_MANUAL, 16'h0000});
    foreach (rows[i]) begin
      host.xfer(1'b1, ad(2'h1, rows[i].off), rows[i].wd);
      check(host.rerr, rows[i].er);
      get(2'h1, rows[i].off, rows[i].rd);
    end
    host.xfer(1'b1, {`CTRL_INDEX, 2'b00}, 16'h000F);
    run_state <= 1'b1;
    // enables are frozen in Run: this clear must be ignored
    host.xfer(1'b1, {`CTRL_INDEX, 2'b00}, 16'h0000);
    host.xfer(1'b0, {`CTRL_INDEX, 2'b00}, 16'h0000);
    check(host.rdat, 32'h0000010F);
    put(2'h0, `OFF_MODE_ONE, 16'h0002);
    put(2'h1, `OFF_MODE_ONE, 16'h0004);
    put(2'h2, `OFF_OUTPUT, 16'h0111);
    put(2'h2, `OFF_MODE_TWO, 16'h0008);
    put(2'h2, `OFF_SP_LO, 16'h0100);
    put(2'h2, `OFF_SP_HI, 16'h0200);
    put(2'h2, `OFF_MODE_ONE, 16'h0002);
    pass();
    check(loop_status[0].mode, loop_mode_pkg::MODE_MANUAL);
    check(loop_status[1].mode, loop_mode_pkg::MODE_MANUAL);
    check(loop_status[2].mode, loop_mode_pkg::MODE_AUTO);
    check(loop_status[2].calc_run, 1'b1);
    check(loop_status[2].setpoint, 16'h0200);
    get(2'h2, `OFF_INTEG, 16'h0111);
    get(2'h2, `OFF_LOCAL_SP, 16'h0456);
    get(2'h2, `OFF_MODE_ONE, 16'h0000);
    run_state <= 1'b0;
    pass();
    check(loop_status[2].mode, loop_mode_pkg::MODE_MANUAL);
    check(loop_status[2].calc_run, 1'b0);
    run_state <= 1'b1;
    pass();
    check(loop_status[2].mode, loop_mode_pkg::MODE_AUTO);
    // power loss in Run: let the pin cross its synchroniser before each pass
    power_fail_pin <= 1'b1;
    repeat (3) @(posedge sys_clk);
    pass();
    check(loop_status[2].mode, loop_mode_pkg::MODE_MANUAL);
    power_fail_pin <= 1'b0;
    repeat (3) @(posedge sys_clk);
    pass();
    check(loop_status[2].mode, loop_mode_pkg::MODE_AUTO);
    loop_error <= 4'h4;
    pass();
    check(loop_status[2].mode, loop_mode_pkg::MODE_MANUAL);
    final_report();
  end
endmodule
